// >>> logic/pmst_map.svh
// Purpose: Command codes, bit positions, reset values and timing figures
//          for the converter status and telemetry command slice.
// Assumes: Included by its bare name; definitions only.
// Notes:   Codes, bit positions, masks and timing used by the logic are named here; widths and exponents stay in the modules.
`ifndef PMST_MAP_SVH
`define PMST_MAP_SVH

// ============================================================
// Command codes
`define PMST_CMD_MFR_STATUS 8'h80
`define PMST_CMD_VIN_WORD 8'h88
`define PMST_CMD_VOUT_WORD 8'h8b
`define PMST_CMD_IOUT_WORD 8'h8c
`define PMST_CMD_CLEAR_FAULTS_DEF 8'h03
`define PMST_PHASE_ALL 8'hff

// ============================================================
// Vendor status byte layout
`define PMST_BIT_POR 7
`define PMST_BIT_SELF 6
`define PMST_BIT_RESET 3
`define PMST_BIT_BACK_CHAN 2
`define PMST_BIT_SYNC 1
`define PMST_MFR_LATCH_MASK 8'h8e
`define PMST_STATUS_RESET 8'h00
`define PMST_BYTE_ZERO 8'h00

// ============================================================
// Linear word layout and reset values
`define PMST_LIN_EXP_MSB 15
`define PMST_LIN_EXP_LSB 11
`define PMST_LIN_MAN_MSB 10
`define PMST_LIN_MAN_W 11
`define PMST_WORD_RESET 16'h0000

// ============================================================
// Timing
`define PMST_CLK_PERIOD_NS 10
`define PMST_REFRESH_NS 1000000

`endif

// >>> logic/pmst_pkg.sv
// Purpose: Types shared by the status and telemetry command slice.
// Assumes: Constants live in pmst_map.svh.
// Notes:   The whole state of the top module is one packed struct.
package pmst_pkg;

  // ============================================================
  // Telemetry word and top-level state
  typedef logic [15:0] pmst_word_t;

  typedef struct packed {
    logic [7:0] latched;
    logic self_live;
    pmst_word_t vin;
    pmst_word_t vout;
    pmst_word_t iout;
    logic [23:0] tick_cnt;
    logic rsp_valid;
    logic rsp_hit;
    pmst_word_t rsp_data;
    logic bad_cmd;
    logic alert;
    logic fault_any;
  } pmst_state_t;

endpackage : pmst_pkg

// >>> logic/pmst_lin11.sv
// Purpose: Encode a signed fixed-point value into the 16-bit linear word.
// Assumes: The input LSB weighs two to the power BASE_EXP.
// Notes:   Pure combinational; shifts right until the mantissa fits.
`timescale 1ns/10ps
`include "pmst_map.svh"

module pmst_lin11
#(
  parameter int IN_W = 20,
  parameter int BASE_EXP = -10
)
(
  input wire logic signed [IN_W-1:0] value,
  output logic [15:0] word
);

  logic signed [IN_W-1:0] v;
  logic signed [5:0] e;

  // True when the value already fits an 11-bit signed mantissa.
  function automatic logic fits(input logic signed [IN_W-1:0] x);
    fits = (x[IN_W-1:`PMST_LIN_MAN_MSB] == '0) ||
           (x[IN_W-1:`PMST_LIN_MAN_MSB] == '1);
  endfunction : fits

  // ============================================================
  // Normalise: the word stands for mantissa times two to exponent.
  always_comb
  begin
    v = value;
    e = 6'(BASE_EXP);
    for (int i = 0; i < IN_W - `PMST_LIN_MAN_W; i++)
    begin
      if (!fits(v))
      begin
        v = v >>> 1;
        e = e + 6'sd1;
      end
    end
    word = {e[4:0], v[`PMST_LIN_MAN_MSB:0]};
  end

endmodule : pmst_lin11

// >>> logic/pmst_status_telemetry.sv
// Purpose: Vendor status byte and input voltage, output voltage and
//          output current readings behind a decoded command port.
// Assumes: Command, event and measurement inputs come from logic on
//          clk; the bus slave and the summary status registers sit
//          outside and consume bad_cmd_pulse and mfr_fault_any.
// Notes:   Readings refresh on a shared interval tick.
`timescale 1ns/10ps
`include "pmst_map.svh"

// What this block does
// - Latch bit 7 on bad power-up check
// - Bit 6 live: self-check busy or followers missing
// - Bits 5:4 and 0 read zero
// - Latch bit 3 on output reset event
// - Latch bit 2 on back-channel fault
// - Latch bit 1 on sync fault
// - Writing one clears a latched bit
// - Each alerting bit has its own mask bit
// - Vin and iout use linear 16-bit format
// - Input voltage refreshed every millisecond
// - Output voltage is a full unsigned word
// - Vout and iout refreshed every millisecond
// - Write to reading flags bad command
// - Phase all ones: master input voltage
// - Other phase: that device's input voltage, master if out of range
// - Phase all ones: summed stack current
// - Other phase: that device's current, master if out of range
// - Follower reports sense pin, ignores scaling
// - Input voltage reading is command 88h
// - Output voltage reading is command 8Bh
// - Output current reading is command 8Ch
// - Status byte 80h, cleared by clear-faults
module pmst_status_telemetry
#(
  parameter int NDEV = 4,
  parameter int VIN_EXP = -10,
  parameter int IOUT_EXP = -8,
  parameter logic [7:0] CLEAR_FAULTS_CODE = `PMST_CMD_CLEAR_FAULTS_DEF,
  parameter int REFRESH_CYCLES = `PMST_REFRESH_NS / `PMST_CLK_PERIOD_NS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic [15:0] rsp_data,
  output logic bad_cmd_pulse,
  input wire logic [7:0] phase_sel,
  input wire logic follower_mode,
  input wire logic por_check_bad,
  input wire logic self_check_busy,
  input wire logic follower_silent,
  input wire logic vout_reset_event,
  input wire logic back_channel_fault,
  input wire logic sync_fault_event,
  input wire logic [7:0] alert_mask_mfr,
  input wire logic [NDEV*16-1:0] vin_dev,
  input wire logic [NDEV*16-1:0] iout_dev,
  input wire logic [15:0] vout_code,
  input wire logic [15:0] sense_pin_code,
  output logic alert_mfr,
  output logic mfr_fault_any
);

  localparam int IN_W = 20;

  pmst_pkg::pmst_state_t s_reg;
  pmst_pkg::pmst_state_t s_next;
  logic signed [IN_W-1:0] vin_raw;
  logic signed [IN_W-1:0] iout_raw;
  pmst_pkg::pmst_word_t vin_word;
  pmst_pkg::pmst_word_t iout_word;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic tick;
  logic rd_req;
  logic wr_req;

  // ============================================================
  // Helper functions

  // Device index for a phase; all ones and out-of-range map to the
  // master, which is device zero.
  function automatic int phase_index(input logic [7:0] ph);
    phase_index = 0;
    if (ph != `PMST_PHASE_ALL && int'(ph) < NDEV)
    begin
      phase_index = int'(ph);
    end
  endfunction : phase_index

  // Pick one 16-bit lane out of a packed per-device bus.
  function automatic logic [15:0] lane(input logic [NDEV*16-1:0] bus,
                                       input int idx);
    lane = bus[idx*16 +: 16];
  endfunction : lane

  // Sum of all signed device currents, widened against overflow.
  function automatic logic signed [IN_W-1:0] sum_lanes(
    input logic [NDEV*16-1:0] bus);
    logic signed [IN_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < NDEV; i++)
    begin
      acc = acc + IN_W'(signed'(bus[i*16 +: 16]));
    end
    sum_lanes = acc;
  endfunction : sum_lanes

  // Status byte as read: latched bits plus the live self-check bit.
  function automatic logic [7:0] mfr_byte(input logic [7:0] lat,
                                          input logic live);
    logic [7:0] b;
    b = lat & `PMST_MFR_LATCH_MASK;
    b[`PMST_BIT_SELF] = live;
    mfr_byte = b;
  endfunction : mfr_byte

  // True for the three read-only telemetry commands.
  function automatic logic is_reading(input logic [7:0] code);
    is_reading = (code == `PMST_CMD_VIN_WORD) ||
                 (code == `PMST_CMD_VOUT_WORD) ||
                 (code == `PMST_CMD_IOUT_WORD);
  endfunction : is_reading

  // ============================================================
  // Phase-dependent measurement selection.

  // Input voltage follows the master or the selected phase device.
  always_comb
  begin
    vin_raw = IN_W'(signed'({1'b0,
      lane(vin_dev, phase_index(phase_sel))}));
  end

  // Output current is the stack total or one device's share.
  always_comb
  begin
    if (phase_sel == `PMST_PHASE_ALL)
    begin
      iout_raw = sum_lanes(iout_dev);
    end
    else
    begin
      iout_raw = IN_W'(signed'(lane(iout_dev,
        phase_index(phase_sel))));
    end
  end

  // Linear encoders for the unsigned input voltage and signed output current readings.
  pmst_lin11
  #(
    .IN_W(IN_W),
    .BASE_EXP(VIN_EXP)
  )
  u_vin_enc
  (
    .value(vin_raw),
    .word(vin_word)
  );

  pmst_lin11
  #(
    .IN_W(IN_W),
    .BASE_EXP(IOUT_EXP)
  )
  u_iout_enc
  (
    .value(iout_raw),
    .word(iout_word)
  );

  // ============================================================
  // Event and clear vectors for the vendor status byte.

  // Request strobes decoded from the command port.
  assign rd_req = cmd_valid && !cmd_write;
  assign wr_req = cmd_valid && cmd_write;
  assign tick = (s_reg.tick_cnt == 24'(REFRESH_CYCLES - 1));

  // Hardware events that set latched bits.
  always_comb
  begin
    set_bits = `PMST_BYTE_ZERO;
    set_bits[`PMST_BIT_POR] = por_check_bad;
    set_bits[`PMST_BIT_RESET] = vout_reset_event;
    set_bits[`PMST_BIT_BACK_CHAN] = back_channel_fault;
    set_bits[`PMST_BIT_SYNC] = sync_fault_event;
  end

  // Host clears: write one to clear, or clear-faults for all bits.
  always_comb
  begin
    clr_bits = `PMST_BYTE_ZERO;
    if (wr_req && cmd_code == `PMST_CMD_MFR_STATUS)
    begin
      clr_bits = cmd_wdata & `PMST_MFR_LATCH_MASK;
    end
    else if (wr_req && cmd_code == CLEAR_FAULTS_CODE)
    begin
      clr_bits = `PMST_MFR_LATCH_MASK;
    end
  end

  // ============================================================
  // Next-state logic for the whole block.
  always_comb
  begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_hit = 1'b0;
    s_next.bad_cmd = 1'b0;

    // A set arriving with its clear wins; unsupported bits stay zero.
    s_next.latched = ((s_reg.latched & ~clr_bits) | set_bits) &
                     `PMST_MFR_LATCH_MASK;
    s_next.self_live = self_check_busy | follower_silent;

    // Refresh interval counter and telemetry capture.
    if (tick)
    begin
      s_next.tick_cnt = '0;
      s_next.vin = vin_word;
      s_next.iout = iout_word;
      if (follower_mode)
      begin
        s_next.vout = sense_pin_code;
      end
      else
      begin
        s_next.vout = vout_code;
      end
    end
    else
    begin
      s_next.tick_cnt = s_reg.tick_cnt + 24'h000001;
    end

    // Reads of owned commands.
    if (rd_req)
    begin
      s_next.rsp_valid = 1'b1;
      unique case (cmd_code)
        `PMST_CMD_MFR_STATUS:
        begin
          s_next.rsp_hit = 1'b1;
          s_next.rsp_data = {`PMST_BYTE_ZERO,
                             mfr_byte(s_reg.latched, s_reg.self_live)};
        end
        `PMST_CMD_VIN_WORD:
        begin
          s_next.rsp_hit = 1'b1;
          s_next.rsp_data = s_reg.vin;
        end
        `PMST_CMD_VOUT_WORD:
        begin
          s_next.rsp_hit = 1'b1;
          s_next.rsp_data = s_reg.vout;
        end
        `PMST_CMD_IOUT_WORD:
        begin
          s_next.rsp_hit = 1'b1;
          s_next.rsp_data = s_reg.iout;
        end
        default:
        begin
          s_next.rsp_data = `PMST_WORD_RESET;
        end
      endcase
    end

    // Writes: status byte accepted, readings refused as bad command.
    if (wr_req)
    begin
      s_next.rsp_valid = 1'b1;
      s_next.rsp_data = `PMST_WORD_RESET;
      if (cmd_code == `PMST_CMD_MFR_STATUS)
      begin
        s_next.rsp_hit = 1'b1;
      end
      else if (is_reading(cmd_code))
      begin
        s_next.rsp_hit = 1'b1;
        s_next.bad_cmd = 1'b1;
      end
    end

    // Alert and summary follow the new latched value.
    s_next.alert = |(s_next.latched & ~alert_mask_mfr);
    s_next.fault_any = |s_next.latched;
  end

  // ============================================================
  // State register with synchronous reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.latched <= `PMST_STATUS_RESET;
      s_reg.vin <= `PMST_WORD_RESET;
      s_reg.vout <= `PMST_WORD_RESET;
      s_reg.iout <= `PMST_WORD_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // Outputs come straight from the state register.
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_hit = s_reg.rsp_hit;
  assign rsp_data = s_reg.rsp_data;
  assign bad_cmd_pulse = s_reg.bad_cmd;
  assign alert_mfr = s_reg.alert;
  assign mfr_fault_any = s_reg.fault_any;

endmodule : pmst_status_telemetry

// >>> testbench/pmst_status_telemetry_chk.sv
// Purpose: Concurrent checks on the status and telemetry command port.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module pmst_status_telemetry_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic [15:0] rsp_data,
  input wire logic bad_cmd_pulse,
  input wire logic por_check_bad,
  input wire logic self_check_busy,
  input wire logic follower_silent,
  input wire logic vout_reset_event,
  input wire logic back_channel_fault,
  input wire logic sync_fault_event,
  input wire logic [7:0] alert_mask_mfr,
  input wire logic alert_mfr,
  input wire logic mfr_fault_any
);
  // ============================================================
  // Checks
  // All checks sample on the rising edge and sleep during reset.
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_rsp_answer: assert property (cmd_valid |=> rsp_valid)
    else $error("command left without an answer");
  chk_bad_write: assert property (cmd_valid && cmd_write &&
    cmd_code inside {8'h88, 8'h8b, 8'h8c} |=> bad_cmd_pulse && rsp_hit)
    else $error("write to a reading not flagged");
  chk_bad_cause: assert property (bad_cmd_pulse |->
    $past(cmd_valid && cmd_write && cmd_code inside {8'h88, 8'h8b, 8'h8c}))
    else $error("bad command flag without a write");
  chk_status_zero: assert property (cmd_valid && !cmd_write &&
    cmd_code == 8'h80 |=> rsp_hit && rsp_data[15:8] == 8'h00 &&
    rsp_data[5:4] == 2'b00 && !rsp_data[0])
    else $error("unsupported status bits not zero");
  chk_self_live: assert property (cmd_valid && !cmd_write &&
    cmd_code == 8'h80 && !$past(rst) |=>
    rsp_data[6] == $past(self_check_busy || follower_silent, 2))
    else $error("live self-check bit wrong");
  chk_sync_alert: assert property (sync_fault_event &&
    !alert_mask_mfr[1] |=> alert_mfr && mfr_fault_any)
    else $error("sync fault not latched or alerted");
  chk_por_latch: assert property (por_check_bad |=> mfr_fault_any)
    else $error("power-up fault not latched");
  chk_mask_quiet: assert property ((alert_mask_mfr == 8'hff)[*2]
    |-> !alert_mfr)
    else $error("alert raised while fully masked");
  chk_clear_all: assert property (cmd_valid && cmd_write &&
    cmd_code == 8'h03 && !(por_check_bad || vout_reset_event ||
    back_channel_fault || sync_fault_event) |=> !mfr_fault_any)
    else $error("clear faults left a latched bit");

  // Main scenarios reached.
  cover property (bad_cmd_pulse);
  cover property (alert_mfr && mfr_fault_any);
  cover property (rsp_valid && rsp_hit && rsp_data[7]);
endmodule : pmst_status_telemetry_chk

bind pmst_status_telemetry pmst_status_telemetry_chk
  i_pmst_status_telemetry_chk
(
  .clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .rsp_valid, .rsp_hit,
  .rsp_data, .bad_cmd_pulse, .por_check_bad, .self_check_busy,
  .follower_silent, .vout_reset_event, .back_channel_fault,
  .sync_fault_event, .alert_mask_mfr, .alert_mfr, .mfr_fault_any
);

// >>> testbench/pmst_host_model.sv
// Purpose: Host side of the decoded command port.
// Assumes: One command per call, answer one cycle after it is taken.
// Notes:   Code and data are scrambled between commands, zero before the first.
`timescale 1ns/10ps
module pmst_host_model
(
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic [15:0] rsp_data,
  input wire logic bad_cmd_pulse
);
  // ============================================================
  // Transfers
  // The port starts idle.
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end

  // Offer one command for one cycle, then take the answer.
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [7:0] wd, output logic ok, output logic hit,
    output logic [15:0] data, output logic bad);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~wd;
    ok = rsp_valid;
    hit = rsp_hit;
    data = rsp_data;
    bad = bad_cmd_pulse;
  endtask : xfer
endmodule : pmst_host_model

// >>> testbench/pmst_status_telemetry_test.sv
// Purpose: Self-checking bench for the status and telemetry slice.
// Assumes: Refresh interval shortened to 20 cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module pmst_status_telemetry_test;
  logic clk, rst, cmd_valid, cmd_write, rsp_valid, rsp_hit, bad_cmd_pulse;
  logic [7:0] cmd_code, cmd_wdata, phase_sel, alert_mask_mfr;
  logic follower_mode, por_check_bad, self_check_busy, follower_silent;
  logic vout_reset_event, back_channel_fault, sync_fault_event;
  logic alert_mfr, mfr_fault_any, ans_ok, ans_hit, ans_bad;
  logic [15:0] rsp_data, vout_code, sense_pin_code, ans_data;
  logic [63:0] vin_dev, iout_dev;
  logic [7:0] ro [3] = '{8'h88, 8'h8b, 8'h8c};
  logic [7:0] ph [4] = '{8'hff, 8'h01, 8'h02, 8'h07};
  int miscompares = 0;
  int samples_checked = 0;
  int idx, s;

  // ============================================================
  // Design and host
  pmst_status_telemetry #(.REFRESH_CYCLES(20)) i_pmst_status_telemetry
  (
    .clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid,
    .rsp_hit, .rsp_data, .bad_cmd_pulse, .phase_sel, .follower_mode,
    .por_check_bad, .self_check_busy, .follower_silent, .vout_reset_event,
    .back_channel_fault, .sync_fault_event, .alert_mask_mfr, .vin_dev,
    .iout_dev, .vout_code, .sense_pin_code, .alert_mfr, .mfr_fault_any
  );
  pmst_host_model i_pmst_host_model
  (
    .clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid,
    .rsp_hit, .rsp_data, .bad_cmd_pulse
  );

  // Encode a value into the linear word without rounding.
  function automatic logic [15:0] lin(input int v, input int e);
    while (v > 1023 || v < -1024)
    begin
      v = v >>> 1;
      e++;
    end
    return {e[4:0], v[10:0]};
  endfunction : lin

  // Read one command and compare the answer.
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    i_pmst_host_model.xfer(1'b0, code, 8'h00, ans_ok, ans_hit, ans_data,
      ans_bad);
    `CHK("answer", 1'b1, ans_ok)
    `CHK("read data", exp, ans_data)
    `CHK("read flag", 1'b0, ans_bad)
  endtask : rd

  // Write one byte and compare ownership and the bad-command flag.
  task automatic wr(input logic [7:0] code, input logic [7:0] wd,
    input logic xhit, input logic xbad);
    i_pmst_host_model.xfer(1'b1, code, wd, ans_ok, ans_hit, ans_data,
      ans_bad);
    `CHK("write answer", 1'b1, ans_ok)
    `CHK("write hit", xhit, ans_hit)
    `CHK("bad command", xbad, ans_bad)
  endtask : wr

  // Raise the chosen fault events for one cycle.
  task automatic pulse(input logic [3:0] ev);
    @(posedge clk);
    #1;
    {por_check_bad, vout_reset_event, back_channel_fault,
      sync_fault_event} = ev;
    @(posedge clk);
    #1;
    {por_check_bad, vout_reset_event, back_channel_fault,
      sync_fault_event} = 4'h0;
  endtask : pulse

  // Print the counts and the verdict, then stop.
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ============================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short well past the expected run length.
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    complete_run;
  end

  // ============================================================
  // Tests
  initial
  begin
    rst = 1'b1;
    {phase_sel, follower_mode, alert_mask_mfr} = 17'h1ff00;
    {por_check_bad, self_check_busy, follower_silent} = 3'h0;
    {vout_reset_event, back_channel_fault, sync_fault_event} = 3'h0;
    vin_dev = {16'h0800, 16'h03e8, 16'h1400, 16'h3000};
    iout_dev = {16'h0100, 16'hff00, 16'h0300, 16'h0500};
    vout_code = 16'h1234;
    sense_pin_code = 16'h0600;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(8'h80, 16'h0000);
    rd(8'h88, 16'h0000);
    wr(8'h80, 8'hff, 1'b1, 1'b0);
    rd(8'h80, 16'h0000);
    self_check_busy = 1'b1;
    pulse(4'hf);
    `CHK("alert", 1'b1, alert_mfr)
    rd(8'h80, 16'h00ce);
    wr(8'h80, 8'h04, 1'b1, 1'b0);
    rd(8'h80, 16'h00ca);
    wr(8'h80, 8'h00, 1'b1, 1'b0);
    rd(8'h80, 16'h00ca);
    wr(8'h03, 8'h00, 1'b0, 1'b0);
    rd(8'h80, 16'h0040);
    {self_check_busy, follower_silent} = 2'b01;
    rd(8'h80, 16'h0040);
    follower_silent = 1'b0;
    rd(8'h80, 16'h0000);
    alert_mask_mfr = 8'h02;
    pulse(4'h1);
    `CHK("masked alert", 1'b0, alert_mfr)
    `CHK("fault summary", 1'b1, mfr_fault_any)
    alert_mask_mfr = 8'hff;
    wr(8'h80, 8'h02, 1'b1, 1'b0);
    `CHK("cleared summary", 1'b0, mfr_fault_any)
    foreach (ro[k])
      wr(ro[k], 8'h5a, 1'b1, 1'b1);
    rd(8'h42, 16'h0000);
    `CHK("unclaimed", 1'b0, ans_hit)
    foreach (ph[k])
    begin
      phase_sel = ph[k];
      follower_mode = k[0];
      repeat (21) @(posedge clk);
      #1;
      idx = (ph[k] == 8'hff || ph[k] > 8'h03) ? 0 : int'(ph[k]);
      s = 0;
      for (int j = 0; j < 4; j++)
        s += int'($signed(iout_dev[j*16 +: 16]));
      rd(8'h88, lin(int'(vin_dev[idx*16 +: 16]), -10));
      rd(8'h8b, k[0] ? sense_pin_code : vout_code);
      if (ph[k] != 8'hff)
        s = int'($signed(iout_dev[idx*16 +: 16]));
      rd(8'h8c, lin(s, -8));
    end
    complete_run;
  end
endmodule : pmst_status_telemetry_test
